// File: include/rmp_pkg.sv
package rmp_pkg;

  // Register byte offsets
  localparam logic [7:0] RMP_OFS_CTRL   = 8'h00;
  localparam logic [7:0] RMP_OFS_COUNT  = 8'h04;
  localparam logic [7:0] RMP_OFS_FREQ   = 8'h08;
  localparam logic [7:0] RMP_OFS_SELECT = 8'h0c;
  localparam logic [7:0] RMP_OFS_CHAN   = 8'h10;
  localparam logic [7:0] RMP_OFS_STATUS = 8'h14;
  localparam logic [7:0] RMP_OFS_CURPOS = 8'h18;

  // Control register fields
  localparam int RMP_CTRL_ACT    = 0;
  localparam int RMP_CTRL_MODE32 = 1;
  localparam int RMP_CTRL_ADAPT  = 2;
  localparam int RMP_CTRL_ADAPT2 = 3;
  localparam int RMP_CTRL_RUN    = 4;
  localparam int RMP_CTRL_W      = 5;

  // Select register fields
  localparam int RMP_SEL_PULSE_LSB = 0;
  localparam int RMP_SEL_DIR_LSB   = 2;

  // Channel register fields
  localparam int RMP_CHAN_FWD_LSB  = 0;
  localparam int RMP_CHAN_REV_LSB  = 4;
  localparam int RMP_CHAN_STOP_LSB = 8;

  // Status register fields
  localparam int RMP_ST_DONE     = 0;
  localparam int RMP_ST_ABN      = 1;
  localparam int RMP_ST_BUSY_LSB = 2;
  localparam int RMP_ST_ACT_LSB  = 6;
  localparam int RMP_ST_DIR      = 10;

  // Reset values
  localparam logic [31:0] RMP_RST_WORD = 32'h0000_0000;

  // Timing and ranges
  localparam logic [24:0] RMP_CLK_HZ      = 25'd20_000_000;
  localparam logic [17:0] RMP_FREQ_MIN    = 18'd10;
  localparam logic [17:0] RMP_FREQ_MAX16  = 18'd32_767;
  localparam logic [17:0] RMP_FREQ_MAXADP = 18'd200_000;
  localparam logic [17:0] RMP_FREQ_MAXTR  = 18'd100_000;
  localparam logic signed [31:0] RMP_CNT_MAX32 = 32'sd999_999;
  localparam logic signed [31:0] RMP_CNT_MIN32 = -32'sd999_999;

  typedef enum logic [3:0]
  {
    RMP_IDLE  = 4'b0001,
    RMP_RUN   = 4'b0010,
    RMP_DECEL = 4'b0100,
    RMP_ABORT = 4'b1000
  } rmp_state_t;

  typedef enum logic [1:0]
  {
    RMP_WHY_NONE  = 2'd0,
    RMP_WHY_DROP  = 2'd1,
    RMP_WHY_LIMIT = 2'd2,
    RMP_WHY_STOP  = 2'd3
  } rmp_why_t;

endpackage : rmp_pkg

// File: src/rmp_top.sv
// Function
// - 32-bit adapter path accepts 10..200000 Hz.
// - 32-bit transistor path accepts 10..100000 Hz.
// - Pulse train goes to the channel chosen by the pulse selector.
// - Adapter channels 2 and 3 exist only with a second adapter.
// - Adapter direction appears on paired outputs 4 to 7.
// - Transistor path drives direction on the chosen destination output.
// - One shared read-only completion flag marks a finished move.
// - One shared read-only abnormal-end flag marks an abnormal end.
// - Each channel shows a read-only busy flag while pulsing.
// - Writable stop command bits, cleared when run changes to stop.
// - Limit in travel direction decelerates, stops, then flags abnormal end.
// - Positive count drives forward raising position, negative reverse lowering.
// - Withdrawn activation decelerates to stop without completion flag.
// - Operand changes during a move wait for the next activation.
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module rmp_top
  import rmp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             pulse_output_0,
  output logic             pulse_output_1,
  output logic             pulse_output_2,
  output logic             pulse_output_3,
  output logic             direction_output_4,
  output logic             direction_output_5,
  output logic             direction_output_6,
  output logic             direction_output_7,
  output logic      [7:0]  direction_transistor_out
);

  // Software-visible state
  logic [RMP_CTRL_W-1:0] ctrl;
  logic [31:0]           relative_pulse_count;
  logic [17:0]           pulse_frequency_setting;
  logic [1:0]            pulse_output_selector;
  logic [2:0]            direction_output_destination;
  logic [3:0]            forward_limit;
  logic [3:0]            reverse_limit;
  logic [3:0]            stop_command;
  logic                  move_complete_flag;
  logic                  move_abnormal_end_flag;
  logic signed [31:0]    current_position;

  // Bus address phase capture
  logic                  wr_pend;
  logic [7:0]            wr_addr;

  // Engine state
  rmp_state_t            state;
  rmp_why_t              why;
  logic                  act_q;
  logic                  run_q;
  logic [1:0]            sel_l;
  logic [2:0]            dest_l;
  logic                  adapt_l;
  logic                  fwd_l;
  logic [19:0]           remaining;
  logic [17:0]           freq_w;
  logic [24:0]           acc;
  logic                  pulse_lvl;

  logic                  addr_ok;
  logic                  act;
  logic                  run_on;
  logic                  act_rise;
  logic                  moving;
  logic signed [31:0]    cnt_eff;
  logic [31:0]           cnt_mag;
  logic [17:0]           freq_eff;
  logic                  start_ok;
  logic [25:0]           acc_sum;
  logic                  tick;
  logic                  fall;
  logic                  last;
  logic                  lim_hit;
  logic [17:0]           freq_half;

  function automatic logic [31:0] rmp_abs(input logic signed [31:0] v);
    rmp_abs = v[31] ? 32'(-v) : 32'(v);
  endfunction : rmp_abs

  // Operand check at activation
  function automatic logic rmp_valid(input logic signed [31:0] cnt,
                                     input logic [17:0]        frq,
                                     input logic               m32,
                                     input logic               adp,
                                     input logic               adp2,
                                     input logic [1:0]         sel);
    logic cnt_ok;
    logic frq_ok;
    logic sel_ok;
    cnt_ok = (cnt != 32'sd0) &&
             (!m32 || (cnt <= RMP_CNT_MAX32 && cnt >= RMP_CNT_MIN32));
    if (!m32)
      frq_ok = frq >= RMP_FREQ_MIN && frq <= RMP_FREQ_MAX16;
    else if (adp)
      frq_ok = frq >= RMP_FREQ_MIN && frq <= RMP_FREQ_MAXADP;
    else
      frq_ok = frq >= RMP_FREQ_MIN && frq <= RMP_FREQ_MAXTR;
    if (adp)
      sel_ok = !sel[1] || adp2;
    else
      sel_ok = sel != 2'd3;
    rmp_valid = cnt_ok && frq_ok && sel_ok;
  endfunction : rmp_valid

  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign act      = ctrl[RMP_CTRL_ACT];
  assign run_on   = ctrl[RMP_CTRL_RUN];
  assign act_rise = act && !act_q;
  assign moving   = state == RMP_RUN || state == RMP_DECEL;

  // 16-bit mode only looks at the low halfword
  assign cnt_eff  = ctrl[RMP_CTRL_MODE32] ? $signed(relative_pulse_count)
                  : 32'($signed(relative_pulse_count[15:0]));
  assign freq_eff = ctrl[RMP_CTRL_MODE32] ? pulse_frequency_setting
                  : {2'b00, pulse_frequency_setting[15:0]};
  assign cnt_mag  = rmp_abs(cnt_eff);
  assign start_ok = rmp_valid(cnt_eff, freq_eff, ctrl[RMP_CTRL_MODE32],
                              ctrl[RMP_CTRL_ADAPT], ctrl[RMP_CTRL_ADAPT2],
                              pulse_output_selector);

  // Half periods from a phase accumulator; no divide needed
  assign acc_sum   = {1'b0, acc} + {7'd0, freq_w, 1'b0};
  assign tick      = moving && (acc_sum >= {1'b0, RMP_CLK_HZ});
  assign fall      = tick && pulse_lvl;
  assign last      = remaining == 20'd1;
  assign lim_hit   = fwd_l ? forward_limit[sel_l] : reverse_limit[sel_l];
  assign freq_half = {1'b0, freq_w[17:1]};

  // Bus write address capture
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= {haddr[7:2], 2'b00};
    end
  end

  // Read data registered in the address phase, unmapped reads zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      hrdata <= RMP_RST_WORD;
    else if (addr_ok && !hwrite)
    begin
      case ({haddr[7:2], 2'b00})
        RMP_OFS_CTRL:   hrdata <= {27'd0, ctrl};
        RMP_OFS_COUNT:  hrdata <= relative_pulse_count;
        RMP_OFS_FREQ:   hrdata <= {14'd0, pulse_frequency_setting};
        RMP_OFS_SELECT: hrdata <= {27'd0, direction_output_destination,
                                   pulse_output_selector};
        RMP_OFS_CHAN:   hrdata <= {20'd0, stop_command, reverse_limit,
                                   forward_limit};
        RMP_OFS_STATUS: hrdata <= {21'd0, fwd_l,
                                   act_flags(),
                                   busy_flags(),
                                   move_abnormal_end_flag,
                                   move_complete_flag};
        RMP_OFS_CURPOS: hrdata <= current_position;
        default:        hrdata <= RMP_RST_WORD;
      endcase
    end
  end

  function automatic logic [3:0] busy_flags();
    busy_flags = moving ? 4'(1 << sel_l) : 4'd0;
  endfunction : busy_flags

  function automatic logic [3:0] act_flags();
    act_flags = (moving && act) ? 4'(1 << sel_l) : 4'd0;
  endfunction : act_flags

  // Operand and control registers; reads of flags have no side effect
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl                         <= '0;
      relative_pulse_count         <= RMP_RST_WORD;
      pulse_frequency_setting      <= '0;
      pulse_output_selector        <= '0;
      direction_output_destination <= '0;
      forward_limit                <= '0;
      reverse_limit                <= '0;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        RMP_OFS_CTRL:  ctrl <= hwdata[RMP_CTRL_W-1:0];
        RMP_OFS_COUNT: relative_pulse_count <= hwdata;
        RMP_OFS_FREQ:  pulse_frequency_setting <= hwdata[17:0];
        RMP_OFS_SELECT:
        begin
          pulse_output_selector <= hwdata[RMP_SEL_PULSE_LSB +: 2];
          direction_output_destination <= hwdata[RMP_SEL_DIR_LSB +: 3];
        end
        RMP_OFS_CHAN:
        begin
          forward_limit <= hwdata[RMP_CHAN_FWD_LSB +: 4];
          reverse_limit <= hwdata[RMP_CHAN_REV_LSB +: 4];
        end
        default: ;
      endcase
    end
  end

  // Stop commands drop on the run-to-stop edge, which beats a write
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      stop_command <= 4'd0;
    else if (run_q && !run_on)
      stop_command <= 4'd0;
    else if (wr_pend && wr_addr == RMP_OFS_CHAN)
      stop_command <= hwdata[RMP_CHAN_STOP_LSB +: 4];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      act_q <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      act_q <= act;
      run_q <= run_on;
    end
  end

  // Move sequencer
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state     <= RMP_IDLE;
      why       <= RMP_WHY_NONE;
      sel_l     <= 2'd0;
      dest_l    <= 3'd0;
      adapt_l   <= 1'b0;
      fwd_l     <= 1'b0;
      remaining <= 20'd0;
      freq_w    <= 18'd0;
    end
    else
    begin
      case (state)
        RMP_IDLE:
        begin
          if (act_rise && run_on && start_ok)
          begin
            // Operands frozen here until the next activation
            sel_l     <= pulse_output_selector;
            dest_l    <= direction_output_destination;
            adapt_l   <= ctrl[RMP_CTRL_ADAPT];
            fwd_l     <= !cnt_eff[31];
            remaining <= cnt_mag[19:0];
            freq_w    <= freq_eff;
            why       <= RMP_WHY_NONE;
            state     <= RMP_RUN;
          end
        end
        RMP_RUN:
        begin
          if (!run_on)
            state <= RMP_ABORT;
          else if (fall && last)
            state <= RMP_IDLE;
          else if (!act)
          begin
            why   <= RMP_WHY_DROP;
            state <= RMP_DECEL;
          end
          else if (lim_hit)
          begin
            why   <= RMP_WHY_LIMIT;
            state <= RMP_DECEL;
          end
          else if (stop_command[sel_l])
          begin
            why   <= RMP_WHY_STOP;
            state <= RMP_DECEL;
          end
          if (fall)
            remaining <= remaining - 20'd1;
        end
        RMP_DECEL:
        begin
          // Halve rate each pulse; never overruns the requested count
          if (!run_on)
            state <= RMP_ABORT;
          else if (fall)
          begin
            remaining <= remaining - 20'd1;
            freq_w    <= freq_half;
            if (last || freq_half < RMP_FREQ_MIN)
              state <= RMP_IDLE;
          end
        end
        RMP_ABORT:
          state <= RMP_IDLE;
        default:
          state <= RMP_IDLE;
      endcase
    end
  end

  // Shared end flags: cleared at a valid start, set at an end other than a withdrawn activation
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      move_complete_flag     <= 1'b0;
      move_abnormal_end_flag <= 1'b0;
    end
    else if (state == RMP_IDLE && act_rise)
    begin
      move_complete_flag     <= 1'b0;
      move_abnormal_end_flag <= !(run_on && start_ok);
    end
    else if (state == RMP_RUN && run_on && fall && last)
      move_complete_flag <= 1'b1;
    else if (state == RMP_DECEL && run_on && fall &&
             (last || freq_half < RMP_FREQ_MIN) && why != RMP_WHY_DROP)
      move_abnormal_end_flag <= 1'b1;
    else if (state == RMP_ABORT)
      move_abnormal_end_flag <= 1'b1;
  end

  // Pulse generator and position counter
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      acc              <= 25'd0;
      pulse_lvl        <= 1'b0;
      current_position <= 32'sd0;
    end
    else if (!moving)
    begin
      acc       <= 25'd0;
      pulse_lvl <= 1'b0;
    end
    else if (tick)
    begin
      acc       <= 25'(acc_sum - {1'b0, RMP_CLK_HZ});
      pulse_lvl <= !pulse_lvl;
      if (pulse_lvl)
        current_position <= fwd_l ? current_position + 32'sd1
                                  : current_position - 32'sd1;
    end
    else
      acc <= acc_sum[24:0];
  end

  // Output routing from flip-flops
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pulse_output_0           <= 1'b0;
      pulse_output_1           <= 1'b0;
      pulse_output_2           <= 1'b0;
      pulse_output_3           <= 1'b0;
      direction_output_4       <= 1'b0;
      direction_output_5       <= 1'b0;
      direction_output_6       <= 1'b0;
      direction_output_7       <= 1'b0;
      direction_transistor_out <= 8'h00;
    end
    else
    begin
      pulse_output_0 <= moving && pulse_lvl && sel_l == 2'd0;
      pulse_output_1 <= moving && pulse_lvl && sel_l == 2'd1;
      pulse_output_2 <= moving && pulse_lvl && sel_l == 2'd2;
      pulse_output_3 <= moving && pulse_lvl && sel_l == 2'd3;
      // Direction holds after the move so the amplifier sees no glitch
      if (moving && adapt_l)
      begin
        direction_output_4 <= sel_l == 2'd0 ? fwd_l : direction_output_4;
        direction_output_5 <= sel_l == 2'd1 ? fwd_l : direction_output_5;
        direction_output_6 <= sel_l == 2'd2 ? fwd_l : direction_output_6;
        direction_output_7 <= sel_l == 2'd3 ? fwd_l : direction_output_7;
      end
      if (moving && !adapt_l)
        direction_transistor_out[dest_l] <= fwd_l;
    end
  end

endmodule : rmp_top

`default_nettype wire

// File: bench/rmp_props.sv
`timescale 1ns/100ps
`default_nettype none

module rmp_props
  import rmp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pulse_output_0,
  input wire logic        pulse_output_1,
  input wire logic        pulse_output_2,
  input wire logic        pulse_output_3,
  input wire logic        direction_output_7,
  input wire logic [7:0]  direction_transistor_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic       take;
  logic       any_pulse;
  logic       rd_q;
  logic       wr_q;
  logic       far_q;
  logic [7:0] adr_q;
  logic [4:0] ctrl_q;

  assign take      = hsel && hready && htrans[1];
  assign any_pulse = pulse_output_0 | pulse_output_1 | pulse_output_2 |
                     pulse_output_3;

  // Shadow of the control word, so readback is judged without the body
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      far_q  <= 1'b0;
      adr_q  <= 8'h00;
      ctrl_q <= 5'h00;
    end
    else
    begin
      rd_q  <= take && !hwrite;
      wr_q  <= take && hwrite;
      far_q <= take && !hwrite && haddr[31:8] == 24'h00_0000 &&
               haddr[7:0] > RMP_OFS_CURPOS;
      adr_q <= haddr[7:0];
      if (wr_q && adr_q == RMP_OFS_CTRL)
        ctrl_q <= hwdata[4:0];
    end
  end

  bus_ready_a: assert property (hreadyout)
    else $error("hreadyout went low");
  bus_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  one_channel_a: assert property ($onehot0({pulse_output_0,
    pulse_output_1,
    pulse_output_2, pulse_output_3}))
    else $error("two pulse outputs active");
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn |=> !any_pulse && hrdata == 32'h0000_0000)
    else $error("outputs busy after reset");
  pulse_gap_a: assert property ($fell(any_pulse) |-> !any_pulse [*8])
    else $error("pulse low phase too short");
  read_hold_a: assert property (!rd_q |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  unmapped_zero_a: assert property (far_q |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (rd_q && adr_q == RMP_OFS_CTRL |->
    hrdata[4:0] == ctrl_q)
    else $error("control readback differs");

  cover property ($rose(pulse_output_0));
  cover property ($rose(pulse_output_3));
  cover property ($rose(direction_output_7));
  cover property ($rose(direction_transistor_out[3]));
endmodule : rmp_props

bind rmp_top rmp_props rmp_props_i (.mclk(mclk), .resetn(resetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pulse_output_0(pulse_output_0),
  .pulse_output_1(pulse_output_1), .pulse_output_2(pulse_output_2),
  .pulse_output_3(pulse_output_3), .direction_output_7(direction_output_7),
  .direction_transistor_out(direction_transistor_out));

`default_nettype wire

// File: bench/rmp_amp_model.sv
`timescale 1ns/100ps
`default_nettype none

module rmp_amp_model
(
  input  wire logic          mclk,
  input  wire logic          pulse,
  input  wire logic          dir,
  output logic signed [31:0] pos,
  output logic        [31:0] edges
);
  logic pulse_q;

  initial
  begin
    pos     = 32'sh0000_0000;
    edges   = 32'h0000_0000;
    pulse_q = 1'b0;
  end

  // Steps on rising edges only; direction taken with the edge
  always @(posedge mclk)
  begin
    pulse_q <= pulse;
    if (pulse && !pulse_q)
    begin
      pos   <= dir ? pos + 32'sh0000_0001 : pos - 32'sh0000_0001;
      edges <= edges + 32'h0000_0001;
    end
  end
endmodule : rmp_amp_model

`default_nettype wire

// File: bench/relative_move_pulse_output_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
  end

module relative_move_pulse_output_tb
  import rmp_pkg::*;
;

  localparam logic [31:0] RUN = 32'h0000_0010;
  localparam logic [31:0] M32 = 32'h0000_0002;
  localparam logic [31:0] ADP = 32'h0000_0004;
  localparam logic [31:0] AD2 = 32'h0000_0008;
  localparam logic [31:0] FAST = 32'h0003_0d40;
  localparam logic [31:0] BAD_CTL [5] = '{RUN, RUN, RUN | M32,
    RUN | M32 | ADP, RUN | M32};
  localparam logic [31:0] BAD_SEL [5] = '{32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0002, 32'h0000_0000};
  localparam logic [31:0] BAD_CNT [5] = '{32'h0000_0000, 32'h0000_0005,
    32'h0000_0005, 32'h0000_0005, 32'h000f_4240};
  localparam logic [31:0] BAD_FRQ [5] = '{32'h0000_03e8, 32'h0000_0009,
    32'h0001_86a1, 32'h0000_03e8, 32'h0000_03e8};
  localparam logic [7:0]  CUT_ADR [3] = '{RMP_OFS_CHAN, RMP_OFS_CTRL,
    RMP_OFS_CHAN};
  localparam logic [31:0] CUT_DAT [3] = '{32'h0000_0001, RUN | M32 | ADP,
    32'h0000_0100};
  localparam logic [1:0]  CUT_FLG [3] = '{2'b10, 2'b00, 2'b10};

  logic               mclk, resetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        [31:0] haddr, hwdata, hrdata, q, st, e0;
  logic        [1:0]  htrans;
  logic        [2:0]  hsize, tr_dest;
  logic        [3:0]  pulse, dir_adp, amp_dir;
  logic        [7:0]  dir_tr;
  logic               adp_sel;
  logic signed [31:0] pos [4];
  logic signed [31:0] p0 [4];
  logic        [31:0] edges [4];
  int                 mismatches, checked;

  always #25 mclk = ~mclk;
  assign hready = hreadyout;

  rmp_top rmp_top_i (.mclk(mclk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pulse_output_0(pulse[0]),
    .pulse_output_1(pulse[1]), .pulse_output_2(pulse[2]),
    .pulse_output_3(pulse[3]), .direction_output_4(dir_adp[0]),
    .direction_output_5(dir_adp[1]), .direction_output_6(dir_adp[2]),
    .direction_output_7(dir_adp[3]), .direction_transistor_out(dir_tr));

  for (genvar k = 0; k < 4; k++)
  begin : g_amp
    assign amp_dir[k] = adp_sel ? dir_adp[k] : dir_tr[tr_dest];
    rmp_amp_model rmp_amp_model_i (.mclk(mclk), .pulse(pulse[k]),
      .dir(amp_dir[k]), .pos(pos[k]), .edges(edges[k]));
  end

  function automatic logic [31:0] total();
    return edges[0] + edges[1] + edges[2] + edges[3];
  endfunction : total

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic give_up(input string what);
    mismatches++;
    $display("unexpected hang in %s", what);
    final_report();
  endtask : give_up

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 64)
        give_up("bus");
      @(posedge mclk);
    end
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rq = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    bus(1'b0, a, 32'h0000_0000, rq);
  endtask : rd

  // Activation is written low first so every move sees a fresh rising edge
  task automatic move(input logic [31:0] ctl, sel, cnt, frq);
    wr(RMP_OFS_SELECT, sel);
    wr(RMP_OFS_COUNT, cnt);
    wr(RMP_OFS_FREQ, frq);
    wr(RMP_OFS_CTRL, ctl);
    p0 = pos;
    e0 = total();
    wr(RMP_OFS_CTRL, ctl | 32'h0000_0001);
    repeat (4) @(posedge mclk);
  endtask : move

  task automatic wait_end(output logic [31:0] rq);
    int n;
    n = 0;
    rd(RMP_OFS_STATUS, rq);
    while (rq[5:2] !== 4'h0)
    begin
      n++;
      if (n > 12000)
        give_up("move");
      rd(RMP_OFS_STATUS, rq);
    end
  endtask : wait_end

  initial
  begin
    mclk = 1'b0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    adp_sel = 1'b0;
    tr_dest = 3'h3;
    mismatches = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4), q);
      `CHK("reset word", 32'h0000_0000, q)
    end
    `CHK("idle pins", 16'h0000, {pulse, dir_adp, dir_tr})
    $display("test reset done");
    move(RUN, 32'h0000_000c, 32'h0000_0005, 32'h0000_7fff);
    wait_end(st);
    `CHK("flags A", 2'b01, st[1:0])
    `CHK("pulses A", 32'h0000_0005, pos[0] - p0[0])
    `CHK("dest dir", 1'b1, dir_tr[3])
    rd(RMP_OFS_CURPOS, q);
    `CHK("position", 32'h0000_0005, q)
    wr(RMP_OFS_STATUS, 32'h0000_0000);
    rd(RMP_OFS_STATUS, q);
    `CHK("flags held", 2'b01, q[1:0])
    $display("test transistor done");
    adp_sel = 1'b1;
    move(RUN | M32 | ADP, 32'h0000_0001, 32'hffff_fffd, FAST);
    rd(RMP_OFS_STATUS, q);
    `CHK("busy ch1", 1'b1, q[RMP_ST_BUSY_LSB + 1])
    wr(RMP_OFS_COUNT, 32'h0000_0064);
    wait_end(st);
    `CHK("pulses B", 32'hffff_fffd, pos[1] - p0[1])
    `CHK("reverse dir", 1'b0, dir_adp[1])
    move(RUN | M32 | ADP | AD2, 32'h0000_0003, 32'h0000_0002,
      FAST);
    wait_end(st);
    `CHK("pulses D", 32'h0000_0002, pos[3] - p0[3])
    `CHK("forward dir", 1'b1, dir_adp[3])
    $display("test adapter done");
    for (int i = 0; i < 5; i++)
    begin
      move(BAD_CTL[i], BAD_SEL[i], BAD_CNT[i],
        BAD_FRQ[i]);
      wait_end(st);
      `CHK("refused flags", 2'b10, st[1:0])
      `CHK("refused pulses", e0, total())
    end
    $display("test refusals done");
    // Cut a few pulses before the end; rate halving makes long tails slow
    for (int i = 0; i < 3; i++)
    begin
      wr(RMP_OFS_CHAN, 32'h0000_0000);
      move(RUN | M32 | ADP, 32'h0000_0000, 32'h0000_0018, FAST);
      repeat (2000) @(posedge mclk);
      wr(CUT_ADR[i], CUT_DAT[i]);
      wait_end(st);
      `CHK("cut flags", CUT_FLG[i], st[1:0])
      `CHK("cut pulses", 32'h0000_0018, pos[0] - p0[0])
    end
    rd(RMP_OFS_CHAN, q);
    `CHK("stop held", 4'h1, q[11:8])
    wr(RMP_OFS_CTRL, 32'h0000_0000);
    rd(RMP_OFS_CHAN, q);
    `CHK("stop cleared", 4'h0, q[11:8])
    $display("test stops done");
    final_report();
  end
endmodule : relative_move_pulse_output_tb

`default_nettype wire
